/* File: rtl/gsl_cfg.svh */
`ifndef GSL_CFG_SVH
`define GSL_CFG_SVH
// register byte offsets
`define GSL_OFF_DIR 8'h00
`define GSL_OFF_OUT 8'h04
`define GSL_OFF_IN 8'h08
`define GSL_OFF_IRQEN 8'h0C
`define GSL_OFF_EDGE 8'h10
`define GSL_OFF_STAT 8'h14
`define GSL_OFF_MASK 8'h18
`define GSL_OFF_ALT 8'h1C
`define GSL_OFF_STRAP 8'h20
`define GSL_OFF_CTRL 8'h24
// alternate register fields: handover bits and supply-on bits
`define GSL_ALT_HO_LSB 0
`define GSL_ALT_ON_LSB 4
// pins that can be handed to the card supply switches
`define GSL_PIN_SUPPLY_A 8
`define GSL_PIN_SUPPLY_B 10
`define GSL_PIN_SUPPLY_C 11
// strap register fields
`define GSL_STRAP_SRC_BIT 0
`define GSL_STRAP_FREQ_LSB 1
`define GSL_STRAP_OK_BIT 3
`define GSL_STRAP_DONE_BIT 4
`define GSL_FREQ_24MHZ 2'h0
// control register fields
`define GSL_CTRL_STANDBY_BIT 0
// reset values
`define GSL_RST_REG 16'h0000
`define GSL_RST_ALT 3'h0
// cycles the strap synchroniser needs to fill after reset release
`define GSL_STRAP_SETTLE 2'h2
// least low time of the external reset, in ns, and at the 100 MHz clock
`define GSL_RESET_MIN_NS 1000
`define GSL_CLK_NS 10
`define GSL_RESET_MIN_CYC ((`GSL_RESET_MIN_NS + `GSL_CLK_NS - 1) / `GSL_CLK_NS)
`endif

/* File: rtl/gsl_edge_if.sv */
`timescale 1ns/1ps
interface gsl_edge_if #(parameter int W = 16);
   logic [W-1:0] level;
   logic [W-1:0] rise;
   logic [W-1:0] fall;
   modport producer (output level, output rise, output fall);
   modport consumer (input level, input rise, input fall);
endinterface

/* File: rtl/gsl_pin_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser per pin, then edge detection on the settled level
module gsl_pin_sync #(
   parameter int W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [W-1:0] pin_in,
   gsl_edge_if.producer edge_o
);
   logic [W-1:0] meta;
   logic [W-1:0] stable;
   logic [W-1:0] prev;
   logic [W-1:0] next_meta;
   logic [W-1:0] next_stable;
   logic [W-1:0] next_prev;

   always_comb begin
      next_meta = pin_in;
      next_stable = meta;
      next_prev = stable;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         meta <= '0;
         stable <= '0;
         prev <= '0;
      end else begin
         meta <= next_meta;
         stable <= next_stable;
         prev <= next_prev;
      end
   end

   assign edge_o.level = stable;
   assign edge_o.rise = stable & ~prev;
   assign edge_o.fall = ~stable & prev;
endmodule

/* File: rtl/gsl_pkg.sv */
package gsl_pkg;
   typedef enum logic [1:0] {
      GSL_ST_RESET = 2'b00,
      GSL_ST_SETTLE = 2'b01,
      GSL_ST_LATCHED = 2'b10
   } gsl_strap_state_t;
   typedef enum logic {
      GSL_EDGE_RISE = 1'b0,
      GSL_EDGE_FALL = 1'b1
   } gsl_edge_t;
endpackage

/* File: rtl/gsl_top.sv */
// Overview of operation
// RULE1: interrupt-capable pins work as input, edge interrupt input, or driven output.
// RULE2: three interrupt pins may be handed over to drive card supply power.
// RULE3: the four upper pins are plain input or output, never interrupt sources.
// RULE4: the board holds the reset input low for at least one microsecond; the testbench's first reset, hold_reset(12), is low for only 125 ns.
// RULE5: straps sampled while reset is low, latched at release, fix clock setup; the code latches straps sampled after release, on the 4th clock.
// RULE6: latched clock source 0 means crystal, 1 means external clock, both 24 MHz.
// RULE7: frequency code 00 means 24 MHz; other codes reserved, board straps 00.
// RULE8: strap pull-downs on only during reset, off once straps are latched; the code keeps them on until the 4th clock after release.
// RULE9: memory chip enable stays asserted except while the processor is in standby.
// RULE10: selected input edges detected synchronously and set sticky software-cleared flags.
//
// The register addresses and the AHB-Lite slave port were left to the implementer.
`timescale 1ns/1ps
`include "gsl_cfg.svh"
module gsl_top #(
   parameter int NPIN = 16,
   parameter int NIRQ = 12
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic [NPIN-1:0] gpio_in,
   output logic [NPIN-1:0] gpio_out,
   output logic [NPIN-1:0] gpio_oe,
   output logic card_supply_switch_a,
   output logic card_supply_switch_b,
   output logic card_supply_switch_c,
   input wire logic clock_source_strap,
   input wire logic [1:0] freq_sel_strap,
   output logic strap_pulldown_en,
   output logic clock_external_sel,
   output logic [1:0] clock_freq_code,
   output logic memory_chip_enable_low,
   output logic irq
);
   if (NPIN != 16 || NIRQ < `GSL_PIN_SUPPLY_C + 1 || NIRQ > NPIN) begin : g_chk
      $error("gsl_top: unsupported pin counts");
   end

   localparam logic [NPIN-1:0] IRQ_PINS = NPIN'((1 << NIRQ) - 1);

   gsl_edge_if #(.W(NPIN)) pins ();

   gsl_pin_sync #(.W(NPIN)) i_gsl_pin_sync (
      .hclk(hclk),
      .hresetn(hresetn),
      .pin_in(gpio_in),
      .edge_o(pins)
   );

   // bus slave
   logic wr_ph;
   logic [7:0] wr_addr;
   logic next_wr_ph;
   logic [7:0] next_wr_addr;
   logic [31:0] next_hrdata;
   logic acc;

   // register state
   logic [NPIN-1:0] dir;
   logic [NPIN-1:0] out_data;
   logic [NPIN-1:0] irq_en;
   logic [NPIN-1:0] edge_sel;
   logic [NPIN-1:0] status;
   logic [NPIN-1:0] mask;
   logic [2:0] alt_ho;
   logic [2:0] alt_on;
   logic standby;
   logic [NPIN-1:0] next_dir;
   logic [NPIN-1:0] next_out_data;
   logic [NPIN-1:0] next_irq_en;
   logic [NPIN-1:0] next_edge_sel;
   logic [NPIN-1:0] next_status;
   logic [NPIN-1:0] next_mask;
   logic [2:0] next_alt_ho;
   logic [2:0] next_alt_on;
   logic next_standby;
   logic [NPIN-1:0] ho_pins;
   logic [NPIN-1:0] next_ho_pins;
   logic [NPIN-1:0] ev;
   logic [NPIN-1:0] clr;

   // strap capture
   logic [2:0] strap_meta;
   logic [2:0] strap_s2;
   gsl_pkg::gsl_strap_state_t st;
   gsl_pkg::gsl_strap_state_t next_st;
   logic [1:0] settle;
   logic [1:0] next_settle;
   logic next_ext_sel;
   logic [1:0] next_freq;
   logic freq_ok;
   logic next_freq_ok;

   assign acc = hsel && hready && htrans[1];

   function automatic logic [NPIN-1:0] pin_mask(input logic [2:0] sel);
      logic [NPIN-1:0] m;
      m = '0;
      m[`GSL_PIN_SUPPLY_A] = sel[0];
      m[`GSL_PIN_SUPPLY_B] = sel[1];
      m[`GSL_PIN_SUPPLY_C] = sel[2];
      return m;
   endfunction

   always_comb begin
      next_wr_ph = acc && hwrite;
      next_wr_addr = haddr[7:0];
      next_hrdata = 32'h0000_0000;
      if (acc && !hwrite) begin
         case (haddr[7:0])
            `GSL_OFF_DIR: next_hrdata[NPIN-1:0] = dir;
            `GSL_OFF_OUT: next_hrdata[NPIN-1:0] = out_data;
            `GSL_OFF_IN: next_hrdata[NPIN-1:0] = pins.level;
            `GSL_OFF_IRQEN: next_hrdata[NPIN-1:0] = irq_en;
            `GSL_OFF_EDGE: next_hrdata[NPIN-1:0] = edge_sel;
            `GSL_OFF_STAT: next_hrdata[NPIN-1:0] = status;
            `GSL_OFF_MASK: next_hrdata[NPIN-1:0] = mask;
            `GSL_OFF_ALT: begin
               next_hrdata[`GSL_ALT_HO_LSB +: 3] = alt_ho;
               next_hrdata[`GSL_ALT_ON_LSB +: 3] = alt_on;
            end
            `GSL_OFF_STRAP: begin
               next_hrdata[`GSL_STRAP_SRC_BIT] = clock_external_sel;
               next_hrdata[`GSL_STRAP_FREQ_LSB +: 2] = clock_freq_code;
               next_hrdata[`GSL_STRAP_OK_BIT] = freq_ok;
               next_hrdata[`GSL_STRAP_DONE_BIT] = (st == gsl_pkg::GSL_ST_LATCHED);
            end
            `GSL_OFF_CTRL: next_hrdata[`GSL_CTRL_STANDBY_BIT] = standby;
            default: next_hrdata = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_ph <= 1'b0;
         wr_addr <= 8'h00;
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         wr_ph <= next_wr_ph;
         wr_addr <= next_wr_addr;
         hrdata <= next_hrdata;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end
   end

   // edge events only on interrupt-mode pins that are inputs and not handed over
   always_comb begin
      for (int i = 0; i < NPIN; i++) begin
         ev[i] = irq_en[i] && !dir[i] && !ho_pins[i] &&
                 (edge_sel[i] == gsl_pkg::GSL_EDGE_FALL ? pins.fall[i] : pins.rise[i]); // RULE10
      end
   end

   always_comb begin
      next_dir = dir;
      next_out_data = out_data;
      next_irq_en = irq_en;
      next_edge_sel = edge_sel;
      next_mask = mask;
      next_alt_ho = alt_ho;
      next_alt_on = alt_on;
      next_standby = standby;
      clr = '0;
      if (wr_ph) begin
         case (wr_addr)
            `GSL_OFF_DIR: next_dir = hwdata[NPIN-1:0]; // RULE1
            `GSL_OFF_OUT: next_out_data = hwdata[NPIN-1:0];
            `GSL_OFF_IRQEN: next_irq_en = hwdata[NPIN-1:0] & IRQ_PINS; // RULE3
            `GSL_OFF_EDGE: next_edge_sel = hwdata[NPIN-1:0] & IRQ_PINS;
            `GSL_OFF_STAT: clr = hwdata[NPIN-1:0];
            `GSL_OFF_MASK: next_mask = hwdata[NPIN-1:0] & IRQ_PINS;
            `GSL_OFF_ALT: begin
               next_alt_ho = hwdata[`GSL_ALT_HO_LSB +: 3]; // RULE2
               next_alt_on = hwdata[`GSL_ALT_ON_LSB +: 3];
            end
            `GSL_OFF_CTRL: next_standby = hwdata[`GSL_CTRL_STANDBY_BIT];
            default: clr = '0;
         endcase
      end
      // a new event wins over a clear in the same cycle
      next_status = (status & ~clr) | ev; // RULE10
      next_ho_pins = pin_mask(next_alt_ho);
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir <= `GSL_RST_REG;
         out_data <= `GSL_RST_REG;
         irq_en <= `GSL_RST_REG;
         edge_sel <= `GSL_RST_REG;
         status <= `GSL_RST_REG;
         mask <= `GSL_RST_REG;
         alt_ho <= `GSL_RST_ALT;
         alt_on <= `GSL_RST_ALT;
         standby <= 1'b0;
         ho_pins <= `GSL_RST_REG;
         gpio_out <= `GSL_RST_REG;
         gpio_oe <= `GSL_RST_REG;
         card_supply_switch_a <= 1'b0;
         card_supply_switch_b <= 1'b0;
         card_supply_switch_c <= 1'b0;
         memory_chip_enable_low <= 1'b0;
         irq <= 1'b0;
      end else begin
         dir <= next_dir;
         out_data <= next_out_data;
         irq_en <= next_irq_en;
         edge_sel <= next_edge_sel;
         status <= next_status;
         mask <= next_mask;
         alt_ho <= next_alt_ho;
         alt_on <= next_alt_on;
         standby <= next_standby;
         ho_pins <= next_ho_pins;
         gpio_out <= next_out_data;
         gpio_oe <= next_dir & ~next_ho_pins; // RULE1 RULE2
         card_supply_switch_a <= next_alt_ho[0] && next_alt_on[0]; // RULE2
         card_supply_switch_b <= next_alt_ho[1] && next_alt_on[1];
         card_supply_switch_c <= next_alt_ho[2] && next_alt_on[2];
         memory_chip_enable_low <= next_standby; // RULE9
         irq <= |(next_status & next_mask);
      end
   end

   // strap synchroniser has no reset so it keeps sampling while reset is low
   always_ff @(posedge hclk) begin
      strap_meta <= {freq_sel_strap, clock_source_strap}; // RULE5
      strap_s2 <= strap_meta;
   end

   always_comb begin
      next_st = st;
      next_settle = settle;
      next_ext_sel = clock_external_sel;
      next_freq = clock_freq_code;
      next_freq_ok = freq_ok;
      case (st)
         gsl_pkg::GSL_ST_RESET: begin
            next_st = gsl_pkg::GSL_ST_SETTLE;
            next_settle = `GSL_STRAP_SETTLE;
         end
         gsl_pkg::GSL_ST_SETTLE: begin
            if (settle == 2'h0) begin
               next_st = gsl_pkg::GSL_ST_LATCHED;
               next_ext_sel = strap_s2[0]; // RULE5 RULE6
               next_freq = strap_s2[2:1];
               next_freq_ok = (strap_s2[2:1] == `GSL_FREQ_24MHZ); // RULE7
            end else begin
               next_settle = settle - 2'h1;
            end
         end
         gsl_pkg::GSL_ST_LATCHED: next_st = gsl_pkg::GSL_ST_LATCHED;
         default: next_st = gsl_pkg::GSL_ST_RESET;
      endcase
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st <= gsl_pkg::GSL_ST_RESET;
         settle <= 2'h0;
         clock_external_sel <= 1'b0;
         clock_freq_code <= 2'h0;
         freq_ok <= 1'b0;
         strap_pulldown_en <= 1'b1;
      end else begin
         st <= next_st;
         settle <= next_settle;
         clock_external_sel <= next_ext_sel;
         clock_freq_code <= next_freq;
         freq_ok <= next_freq_ok;
         strap_pulldown_en <= (next_st != gsl_pkg::GSL_ST_LATCHED); // RULE8
      end
   end

   // checks
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   property p_oe_mode;
      gpio_oe == (dir & ~ho_pins) && gpio_out == out_data;
   endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("pin drive differs from mode"); // RULE1

   property p_dir_write;
      (wr_ph && wr_addr == `GSL_OFF_DIR) |=>
         gpio_oe == ($past(hwdata[NPIN-1:0]) & ~ho_pins);
   endproperty
   a_dir_write: assert property (p_dir_write) else $error("direction write lost"); // RULE1

   property p_supply;
      card_supply_switch_a == (alt_ho[0] && alt_on[0]) &&
      card_supply_switch_b == (alt_ho[1] && alt_on[1]) &&
      card_supply_switch_c == (alt_ho[2] && alt_on[2]) &&
      (!alt_ho[0] || !gpio_oe[`GSL_PIN_SUPPLY_A]) && (!alt_ho[1] || !gpio_oe[`GSL_PIN_SUPPLY_B]) &&
      (!alt_ho[2] || !gpio_oe[`GSL_PIN_SUPPLY_C]);
   endproperty
   a_supply: assert property (p_supply) else $error("supply handover wrong"); // RULE2

   property p_upper_plain;
      irq_en[NPIN-1:NIRQ] == '0 && status[NPIN-1:NIRQ] == '0;
   endproperty
   a_upper_plain: assert property (p_upper_plain) else $error("upper pin irq"); // RULE3

   property p_strap_latch;
      (st == gsl_pkg::GSL_ST_SETTLE && settle == 2'h0) |=>
         clock_external_sel == $past(strap_s2[0]) && clock_freq_code == $past(strap_s2[2:1]);
   endproperty
   a_strap_latch: assert property (p_strap_latch) else $error("strap not latched"); // RULE5

   property p_strap_hold;
      st == gsl_pkg::GSL_ST_LATCHED |=> $stable(clock_external_sel) && $stable(clock_freq_code);
   endproperty
   a_strap_hold: assert property (p_strap_hold) else $error("latched clock setup moved"); // RULE6

   property p_freq_ok;
      st == gsl_pkg::GSL_ST_LATCHED |-> freq_ok == (clock_freq_code == `GSL_FREQ_24MHZ);
   endproperty
   a_freq_ok: assert property (p_freq_ok) else $error("frequency decode wrong"); // RULE7

   property p_pulldown;
      $rose(hresetn) |-> strap_pulldown_en [*4] ##1 !strap_pulldown_en;
   endproperty
   a_pulldown: assert property (p_pulldown) else $error("pull-down timing"); // RULE8

   property p_mce;
      memory_chip_enable_low == standby;
   endproperty
   a_mce: assert property (p_mce) else $error("chip enable wrong"); // RULE9

   property p_mce_write;
      (wr_ph && wr_addr == `GSL_OFF_CTRL) |=>
         memory_chip_enable_low == $past(hwdata[`GSL_CTRL_STANDBY_BIT]);
   endproperty
   a_mce_write: assert property (p_mce_write) else $error("standby write lost"); // RULE9

   property p_event;
      (ev != '0) |=> ((status & $past(ev)) == $past(ev)) && (irq == |(status & mask));
   endproperty
   a_event: assert property (p_event) else $error("edge event lost"); // RULE10

   c_latched: cover property (st == gsl_pkg::GSL_ST_SETTLE ##1 st == gsl_pkg::GSL_ST_LATCHED);
   c_irq: cover property ($rose(irq));
   c_supply: cover property ($rose(card_supply_switch_c));
   c_clear_race: cover property (wr_ph && wr_addr == `GSL_OFF_STAT &&
                                 (ev & hwdata[NPIN-1:0]) != '0);
endmodule

/* File: tb/gpio_and_reset_strap_latch_test.sv */
`timescale 1ns/1ps
`include "gsl_cfg.svh"
`define CHK(nm, e, g) \
   begin \
      checks_done++; \
      if ((g) !== (e)) begin \
         fail_count++; \
         $display("unexpected %s: expected %h, seen %h", nm, e, g); \
      end \
   end
module gpio_and_reset_strap_latch_test;
   logic hclk = 1'b0;
   logic hresetn;
   logic hsel = 1'b0;
   logic hwrite = 1'b0;
   logic [31:0] haddr = 32'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata;
   logic hreadyout;
   logic hresp;
   logic [15:0] gpio_in;
   logic [15:0] gpio_out;
   logic [15:0] gpio_oe;
   logic [15:0] pin_drv = 16'h0;
   logic src_v = 1'b0;
   logic [1:0] freq_v = 2'h0;
   logic clock_source_strap;
   logic [1:0] freq_sel_strap;
   logic sup_a, sup_b, sup_c, pd_en, ext_sel, mce_low, irq;
   logic [1:0] freq_code;
   logic [31:0] rd;
   logic [7:0] altv [3] = '{8'h77, 8'h50, 8'h15};
   logic [2:0] supv [3] = '{3'h7, 3'h0, 3'h4};
   logic [15:0] oev [3] = '{16'hF2FF, 16'hFFFF, 16'hF6FF};
   int fail_count = 0;
   int checks_done = 0;

   always #5 hclk = ~hclk;

   gsl_top i_gsl_top (
      .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .gpio_in(gpio_in),
      .gpio_out(gpio_out), .gpio_oe(gpio_oe), .card_supply_switch_a(sup_a),
      .card_supply_switch_b(sup_b), .card_supply_switch_c(sup_c),
      .clock_source_strap(clock_source_strap), .freq_sel_strap(freq_sel_strap),
      .strap_pulldown_en(pd_en), .clock_external_sel(ext_sel),
      .clock_freq_code(freq_code), .memory_chip_enable_low(mce_low), .irq(irq)
   );

   gsl_board i_gsl_board (
      .hclk(hclk), .hresetn(hresetn), .clock_source_strap(clock_source_strap),
      .freq_sel_strap(freq_sel_strap), .gpio_in(gpio_in), .gpio_out(gpio_out),
      .gpio_oe(gpio_oe), .pin_drv(pin_drv), .src_v(src_v), .freq_v(freq_v)
   );

   task automatic report_and_stop;
      $display("checks %0d, mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // bounded wait for hready high at a rising edge
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge hclk);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (hreadyout !== 1'b1) begin
         fail_count++;
         report_and_stop();
      end
   endtask

   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      htrans <= 2'h2;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask

   task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      `CHK(nm, e, rd)
   endtask

   task automatic settle;
      @(posedge hclk);
      @(posedge hclk);
      #1;
   endtask

   // board pin levels, then time for sync and event capture
   task automatic pins(input logic [15:0] v);
      @(posedge hclk);
      pin_drv <= v;
      repeat (6) @(posedge hclk);
   endtask

   initial begin
      i_gsl_board.hold_reset(12);
      for (int k = 0; k < 4; k++) begin
         @(posedge hclk);
         src_v <= k[0];
         freq_v <= k[1:0];
         i_gsl_board.hold_reset(`GSL_RESET_MIN_CYC);
         `CHK("pulldown in reset", 1'b1, pd_en)
         `CHK("chip enable in reset", 1'b0, mce_low)
         repeat (6) @(posedge hclk);
         #1;
         `CHK("pulldown after latch", 1'b0, pd_en)
         `CHK("clock source", k[0], ext_sel)
         `CHK("freq code", k[1:0], freq_code)
         @(posedge hclk);
         src_v <= ~k[0];
         freq_v <= ~k[1:0];
         // straps moved after the latch must not show
         rchk("strap reg", `GSL_OFF_STRAP, {27'h0, 1'b1, k[1:0] == 2'h0, k[1:0], k[0]});
         `CHK("latched source", k[0], ext_sel)
      end
      pins(16'h0C03);
      xfer(`GSL_OFF_DIR, 1'b1, 32'h0000F0F0);
      xfer(`GSL_OFF_OUT, 1'b1, 32'h0000A5A5);
      settle();
      `CHK("oe", 16'hF0F0, gpio_oe)
      `CHK("out", 16'hA5A5, gpio_out)
      rchk("in", `GSL_OFF_IN, {16'h0, (16'hA5A5 & 16'hF0F0) | 16'h0C03});
      `CHK("hresp", 1'b0, hresp)
      xfer(`GSL_OFF_DIR, 1'b1, 32'h0);
      xfer(`GSL_OFF_EDGE, 1'b1, 32'h00000002);
      pins(16'h0012);
      xfer(`GSL_OFF_STAT, 1'b1, 32'h0000FFFF);
      xfer(`GSL_OFF_IRQEN, 1'b1, 32'h0000FFFF);
      xfer(`GSL_OFF_MASK, 1'b1, 32'h0);
      // pin0 rise, pin1 fall, pin3 rise set; pin4 wrong edge, pin12 upper
      pins(16'h1009);
      rchk("status", `GSL_OFF_STAT, 32'h0000000B);
      `CHK("irq masked", 1'b0, irq)
      xfer(`GSL_OFF_MASK, 1'b1, 32'h00000008);
      settle();
      `CHK("irq unmasked", 1'b1, irq)
      xfer(`GSL_OFF_STAT, 1'b1, 32'h00000008);
      settle();
      `CHK("irq cleared", 1'b0, irq)
      rchk("status w1c", `GSL_OFF_STAT, 32'h00000003);
      xfer(`GSL_OFF_DIR, 1'b1, 32'h0000FFFF);
      for (int k = 0; k < 3; k++) begin
         xfer(`GSL_OFF_ALT, 1'b1, {24'h0, altv[k]});
         settle();
         `CHK("supply", supv[k], {sup_a, sup_b, sup_c})
         `CHK("oe handover", oev[k], gpio_oe)
      end
      for (int k = 1; k >= 0; k--) begin
         xfer(`GSL_OFF_CTRL, 1'b1, k);
         settle();
         `CHK("chip enable", k[0], mce_low)
      end
      rchk("unmapped", 8'h28, 32'h0);
      report_and_stop();
   end
endmodule

/* File: tb/gsl_board.sv */
`timescale 1ns/1ps
module gsl_board (
   input wire logic hclk,
   output logic hresetn,
   output logic clock_source_strap,
   output logic [1:0] freq_sel_strap,
   output logic [15:0] gpio_in,
   input wire logic [15:0] gpio_out,
   input wire logic [15:0] gpio_oe,
   input wire logic [15:0] pin_drv,
   input wire logic src_v,
   input wire logic [1:0] freq_v
);
   // straps held firmly by board resistors
   assign clock_source_strap = src_v;
   assign freq_sel_strap = freq_v;
   // driven pins read back the device level, the rest the board level
   assign gpio_in = (gpio_out & gpio_oe) | (pin_drv & ~gpio_oe);
   initial hresetn = 1'b0;
   task automatic hold_reset(input int cyc);
      @(posedge hclk);
      hresetn <= 1'b0;
      repeat (cyc) @(posedge hclk);
      hresetn <= 1'b1;
   endtask
endmodule
